// >>> design/esq_pkg.sv
// Shared constants of the engine state qualifier
package esq_pkg;
   // ----------------------------------------------------------
   // Widths
   // ----------------------------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int STRB_W  = 4;
   localparam int VAL_W   = 16;
   localparam int NUM_THR = 8;
   localparam int STATE_W = 9;
   localparam int CTRL_W  = 2;
   localparam int IDX_W   = 6;

   // ----------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_THR_BASE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_THR_LAST = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STATE    = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h2C;
   localparam logic [IDX_W-1:0]  THR_IDX_BASE = 6'h01;

   // ----------------------------------------------------------
   // Threshold table indices (one word each)
   // ----------------------------------------------------------
   localparam int TH_SPEED      = 0;
   localparam int TH_SLOW_ACC   = 1;
   localparam int TH_FAST_ACC   = 2;
   localparam int TH_SLOW_DEC   = 3;
   localparam int TH_FAST_DEC   = 4;
   localparam int TH_THR_CLOSED = 5;
   localparam int TH_WIDE_OPEN  = 6;
   localparam int TH_MAP_OVR    = 7;

   // Threshold reset values, index 7 first
   localparam logic [NUM_THR-1:0][VAL_W-1:0] THR_RESET = {
      16'h0000, 16'h03E2, 16'h000A, 16'h0190,
      16'h0064, 16'h0190, 16'h0064, 16'h0000};

   // ----------------------------------------------------------
   // Control bits and state bit positions
   // ----------------------------------------------------------
   localparam int CTRL_SPEED_GATE = 0;
   localparam int CTRL_VALVE_WIDE = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

   localparam int ST_SPEED_HIGH   = 0;
   localparam int ST_SLOW_ACC     = 1;
   localparam int ST_FAST_ACC     = 2;
   localparam int ST_SLOW_DEC     = 3;
   localparam int ST_FAST_DEC     = 4;
   localparam int ST_TPS_CLOSED   = 5;
   localparam int ST_WIDE_OPEN    = 6;
   localparam int ST_OVERRUN      = 7;
   localparam int ST_IDLING       = 8;

   // ----------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> design/esq_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ns
`default_nettype none
module esq_axil_slave (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // AXI4-Lite
   input  wire logic [esq_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [esq_pkg::DATA_W-1:0] wdata,
   input  wire logic [esq_pkg::STRB_W-1:0] wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [esq_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [esq_pkg::DATA_W-1:0]      rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   // Register side
   output logic                            wrEn,
   output logic [esq_pkg::ADDR_W-1:0]      wrAddr,
   output logic [esq_pkg::DATA_W-1:0]      wrData,
   output logic [esq_pkg::STRB_W-1:0]      wrStrb,
   input  wire logic                       wrOk,
   output logic                            rdEn,
   output logic [esq_pkg::ADDR_W-1:0]      rdAddr,
   input  wire logic [esq_pkg::DATA_W-1:0] rdData,
   input  wire logic                       rdOk
);
   import esq_pkg::*;

   typedef struct packed {
      logic              awHave;
      logic [ADDR_W-1:0] awAddr;
      logic              wHave;
      logic [DATA_W-1:0] wData;
      logic [STRB_W-1:0] wStrb;
      logic              bValid;
      logic [1:0]        bResp;
      logic              rValid;
      logic [DATA_W-1:0] rData;
      logic [1:0]        rResp;
   } esq_slv_s;

   esq_slv_s s_r;
   esq_slv_s s_nxt;

   // Ports from the state; rdEn and rdAddr come from the AR channel
   assign awready = !s_r.awHave && !s_r.bValid;
   assign wready  = !s_r.wHave && !s_r.bValid;
   assign arready = !s_r.rValid;
   assign bvalid  = s_r.bValid;
   assign bresp   = s_r.bResp;
   assign rvalid  = s_r.rValid;
   assign rdata   = s_r.rData;
   assign rresp   = s_r.rResp;
   assign wrEn    = s_r.awHave && s_r.wHave && !s_r.bValid;
   assign wrAddr  = s_r.awAddr;
   assign wrData  = s_r.wData;
   assign wrStrb  = s_r.wStrb;
   assign rdEn    = arvalid && !s_r.rValid;
   assign rdAddr  = araddr;

   // Channel handshakes
   always_comb begin
      s_nxt = s_r;
      if (awvalid && awready) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wData = wdata;
         s_nxt.wStrb = wstrb;
      end
      if (wrEn) begin
         s_nxt.awHave = 1'b0;
         s_nxt.wHave  = 1'b0;
         s_nxt.bValid = 1'b1;
         s_nxt.bResp  = wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_r.bValid && bready) begin
         s_nxt.bValid = 1'b0;
      end
      if (rdEn) begin
         s_nxt.rValid = 1'b1;
         s_nxt.rData  = rdData;
         s_nxt.rResp  = rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_r.rValid && rready) begin
         s_nxt.rValid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> design/esq_compare.sv
// Threshold comparators producing the raw engine state bits
`timescale 1ns/1ns
`default_nettype none
module esq_compare (
   // Sensor values
   input  wire logic        [esq_pkg::VAL_W-1:0]                      vehicleSpeed,
   input  wire logic        [esq_pkg::VAL_W-1:0]                      throttlePosition,
   input  wire logic        [esq_pkg::VAL_W-1:0]                      manifoldPressure,
   input  wire logic signed [esq_pkg::VAL_W-1:0]                      engineSpeedRate,
   // Thresholds
   input  wire logic [esq_pkg::NUM_THR-1:0][esq_pkg::VAL_W-1:0]       thr,
   // Result
   output logic [esq_pkg::STATE_W-1:0]                                state
);
   import esq_pkg::*;

   logic signed [VAL_W:0] rateX;
   assign rateX = {engineSpeedRate[VAL_W-1], engineSpeedRate};

   // Signed rate against the two accel and two decel limits
   for (genvar g = 0; g < 4; g++) begin : g_rate
      logic signed [VAL_W:0] lim;
      assign lim = $signed({1'b0, thr[TH_SLOW_ACC+g]});
      if (g < 2) begin : g_acc
         assign state[ST_SLOW_ACC+g] = rateX > lim;
      end else begin : g_dec
         assign state[ST_SLOW_ACC+g] = rateX < -lim;
      end
   end

   // Unsigned sensor thresholds
   assign state[ST_SPEED_HIGH] = vehicleSpeed > thr[TH_SPEED];
   assign state[ST_TPS_CLOSED] = throttlePosition < thr[TH_THR_CLOSED];
   assign state[ST_WIDE_OPEN]  = throttlePosition > thr[TH_WIDE_OPEN];
   assign state[ST_OVERRUN]    = manifoldPressure < thr[TH_MAP_OVR];
   assign state[ST_IDLING]     = state[ST_TPS_CLOSED] && !state[ST_OVERRUN];
endmodule
`default_nettype wire

// >>> design/esq_core.sv
// Engine state qualifier top: state flags, consumer gating, registers
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module esq_core (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // Conditioned sensor inputs
   input  wire logic                              sampleValid,
   input  wire logic        [esq_pkg::VAL_W-1:0]  vehicleSpeed,
   input  wire logic        [esq_pkg::VAL_W-1:0]  throttlePosition,
   input  wire logic        [esq_pkg::VAL_W-1:0]  manifoldPressure,
   input  wire logic signed [esq_pkg::VAL_W-1:0]  engineSpeedRate,
   // Consumer gating
   output logic                                   closedLoopIdleEn,
   output logic                                   idleTimingEn,
   output logic                                   idleFuelTableEn,
   output logic                                   overrunCutEn,
   output logic                                   idleValveOpenFullThrottle,
   output logic [esq_pkg::STATE_W-1:0]            engineState,
   // Interrupt
   output logic                                   irq,
   // AXI4-Lite
   input  wire logic [esq_pkg::ADDR_W-1:0]        awaddr,
   input  wire logic                              awvalid,
   output logic                                   awready,
   input  wire logic [esq_pkg::DATA_W-1:0]        wdata,
   input  wire logic [esq_pkg::STRB_W-1:0]        wstrb,
   input  wire logic                              wvalid,
   output logic                                   wready,
   output logic [1:0]                             bresp,
   output logic                                   bvalid,
   input  wire logic                              bready,
   input  wire logic [esq_pkg::ADDR_W-1:0]        araddr,
   input  wire logic                              arvalid,
   output logic                                   arready,
   output logic [esq_pkg::DATA_W-1:0]             rdata,
   output logic [1:0]                             rresp,
   output logic                                   rvalid,
   input  wire logic                              rready
);
   import esq_pkg::*;

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed {
      logic [CTRL_W-1:0]              ctrl;
      logic [NUM_THR-1:0][VAL_W-1:0]  thr;
      logic [STATE_W-1:0]             state;
      logic [STATE_W-1:0]             status;
      logic [STATE_W-1:0]             mask;
      logic                           clIdle;
      logic                           idleTiming;
      logic                           idleFuel;
      logic                           overrunCut;
      logic                           valveOpen;
      logic                           irq;
   } esq_core_s;

   esq_core_s s_r;
   esq_core_s s_nxt;

   // Bus side strobes
   logic                wrEn;
   logic [ADDR_W-1:0]   wrAddr;
   logic [DATA_W-1:0]   wrData;
   logic [STRB_W-1:0]   wrStrb;
   logic                wrOk;
   logic                rdEn;
   logic [ADDR_W-1:0]   rdAddr;
   logic [DATA_W-1:0]   rdData;
   logic                rdOk;
   logic [STATE_W-1:0]  rawState;

   // Merge written byte lanes into a 16-bit field
   function automatic logic [VAL_W-1:0] mergeLanes(
      input logic [VAL_W-1:0]  old,
      input logic [DATA_W-1:0] data,
      input logic [STRB_W-1:0] strb
   );
      logic [VAL_W-1:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // True when an address falls in the threshold table
   function automatic logic isThr(input logic [ADDR_W-1:0] a);
      return (a >= OFF_THR_BASE) && (a <= OFF_THR_LAST) && (a[1:0] == 2'h0);
   endfunction

   // ----------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------
   esq_axil_slave u_slave (
      .clk     (clk),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrEn    (wrEn),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .wrOk    (wrOk),
      .rdEn    (rdEn),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdOk    (rdOk)
   );

   esq_compare u_compare (
      .vehicleSpeed     (vehicleSpeed),
      .throttlePosition (throttlePosition),
      .manifoldPressure (manifoldPressure),
      .engineSpeedRate  (engineSpeedRate),
      .thr              (s_r.thr),
      .state            (rawState)
   );

   // ----------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------
   always_comb begin
      logic [IDX_W-1:0] idx;
      idx    = rdAddr[ADDR_W-1:2] - THR_IDX_BASE;
      rdData = '0;
      rdOk   = 1'b1;
      if (rdAddr == OFF_CTRL) begin
         rdData[CTRL_W-1:0] = s_r.ctrl;
      end else if (isThr(rdAddr)) begin
         rdData[VAL_W-1:0] = s_r.thr[idx[2:0]];
      end else if (rdAddr == OFF_STATE) begin
         rdData[STATE_W-1:0] = s_r.state;
      end else if (rdAddr == OFF_IRQ_STAT) begin
         rdData[STATE_W-1:0] = s_r.status;
      end else if (rdAddr == OFF_IRQ_MASK) begin
         rdData[STATE_W-1:0] = s_r.mask;
      end else begin
         rdOk = 1'b0;
      end
   end

   // Write address check
   assign wrOk = (wrAddr == OFF_CTRL) || isThr(wrAddr) || (wrAddr == OFF_STATE)
                 || (wrAddr == OFF_IRQ_STAT) || (wrAddr == OFF_IRQ_MASK);

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      logic [IDX_W-1:0]   idx;
      logic [STATE_W-1:0] st;
      logic [STATE_W-1:0] clr;
      logic [STATE_W-1:0] evt;
      logic               rateQuiet;
      logic               speedOk;
      logic               idleBase;
      idx       = wrAddr[ADDR_W-1:2] - THR_IDX_BASE;
      st        = s_r.state;
      clr       = '0;
      evt       = '0;
      rateQuiet = 1'b1;
      speedOk   = 1'b1;
      idleBase  = 1'b0;
      s_nxt     = s_r;

      // Register writes
      if (wrEn) begin
         if (wrAddr == OFF_CTRL && wrStrb[0]) begin
            s_nxt.ctrl = wrData[CTRL_W-1:0];
         end else if (isThr(wrAddr)) begin
            s_nxt.thr[idx[2:0]] = mergeLanes(s_r.thr[idx[2:0]], wrData, wrStrb);
         end else if (wrAddr == OFF_IRQ_STAT) begin
            clr[7:0] = wrStrb[0] ? wrData[7:0] : 8'h00;
            clr[8]   = wrStrb[1] & wrData[8];
         end else if (wrAddr == OFF_IRQ_MASK) begin
            if (wrStrb[0]) begin
               s_nxt.mask[7:0] = wrData[7:0];
            end
            if (wrStrb[1]) begin
               s_nxt.mask[8] = wrData[8];
            end
         end
      end

      // All flags refresh together on each update
      if (sampleValid) begin
         st  = rawState;
         evt = rawState ^ s_r.state;
      end
      s_nxt.state = st;

      // Consumer gating from the refreshed flags
      rateQuiet = !(st[ST_SLOW_ACC] || st[ST_FAST_ACC]
                    || st[ST_SLOW_DEC] || st[ST_FAST_DEC]);
      speedOk   = !(s_nxt.ctrl[CTRL_SPEED_GATE] && st[ST_SPEED_HIGH]);
      idleBase  = st[ST_TPS_CLOSED] && speedOk;
      s_nxt.clIdle     = idleBase && rateQuiet && !st[ST_OVERRUN];
      s_nxt.idleTiming = idleBase;
      s_nxt.idleFuel   = idleBase;
      s_nxt.overrunCut = st[ST_TPS_CLOSED] && st[ST_OVERRUN]
                         && !st[ST_FAST_DEC] && !st[ST_FAST_ACC];
      s_nxt.valveOpen  = s_nxt.ctrl[CTRL_VALVE_WIDE] && st[ST_WIDE_OPEN];

      // Sticky change events, set beats clear
      s_nxt.status = (s_r.status & ~clr) | evt;
      s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r      <= '0;
         s_r.ctrl <= CTRL_RESET;
         s_r.thr  <= THR_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign closedLoopIdleEn          = s_r.clIdle;
   assign idleTimingEn              = s_r.idleTiming;
   assign idleFuelTableEn           = s_r.idleFuel;
   assign overrunCutEn              = s_r.overrunCut;
   assign idleValveOpenFullThrottle = s_r.valveOpen;
   assign engineState               = s_r.state;
   assign irq                       = s_r.irq;
endmodule
`default_nettype wire

// >>> bench/esq_sensor_model.sv
// Sensor conditioning source model driving one update at a time
`timescale 1ns/1ns
`default_nettype none
module esq_sensor_model (
   // Clock
   input  wire logic                            clk,
   // Conditioned sensor outputs
   output logic                                 sampleValid,
   output logic        [esq_pkg::VAL_W-1:0]     vehicleSpeed,
   output logic        [esq_pkg::VAL_W-1:0]     throttlePosition,
   output logic        [esq_pkg::VAL_W-1:0]     manifoldPressure,
   output logic signed [esq_pkg::VAL_W-1:0]     engineSpeedRate
);
   // Idle values at time zero
   initial begin
      {sampleValid, vehicleSpeed, throttlePosition} = '0;
      {manifoldPressure, engineSpeedRate} = '0;
   end

   // One update after a gap; values scrambled outside the strobe
   task automatic send(input logic [15:0] s, t, m, r, input int gap);
      repeat (gap) @(posedge clk);
      vehicleSpeed <= s;
      throttlePosition <= t;
      manifoldPressure <= m;
      engineSpeedRate <= r;
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      vehicleSpeed <= ~s;
      throttlePosition <= ~t;
      manifoldPressure <= ~m;
      engineSpeedRate <= ~r;
   endtask
endmodule
`default_nettype wire

// >>> bench/esq_core_asserts.sv
// Port-level assertion checker for the engine state qualifier
`timescale 1ns/1ns
`default_nettype none
module esq_core_asserts (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Sensor strobe and results
   input  wire logic                          sampleValid,
   input  wire logic [esq_pkg::STATE_W-1:0]   engineState,
   input  wire logic                          closedLoopIdleEn,
   input  wire logic                          idleTimingEn,
   input  wire logic                          idleFuelTableEn,
   input  wire logic                          overrunCutEn,
   input  wire logic                          idleValveOpenFullThrottle,
   // Read handshake
   input  wire logic                          arvalid,
   input  wire logic                          arready,
   input  wire logic                          rvalid
);
   import esq_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------
   // Gating relations
   // ----------------------------------------------------------
   AST_CLI_THR: assert property (
      closedLoopIdleEn |-> engineState[ST_TPS_CLOSED] && !engineState[ST_OVERRUN])
      else $error("closed loop idle without closed throttle");
   AST_CLI_RATE: assert property (
      closedLoopIdleEn |-> engineState[ST_FAST_DEC:ST_SLOW_ACC] == 4'h0)
      else $error("closed loop idle during rate excursion");
   AST_IDLE_CLOSED: assert property (
      idleTimingEn || idleFuelTableEn |-> engineState[ST_TPS_CLOSED])
      else $error("idle timing or fuel without closed throttle");
   AST_TIM_FUEL: assert property (
      idleTimingEn == idleFuelTableEn)
      else $error("idle timing and fuel table disagree");
   AST_OVR_CUT: assert property (
      overrunCutEn == (engineState[ST_TPS_CLOSED] && engineState[ST_OVERRUN]
                       && !engineState[ST_FAST_DEC] && !engineState[ST_FAST_ACC]))
      else $error("overrun cut mismatch");
   AST_VALVE: assert property (
      idleValveOpenFullThrottle |-> engineState[ST_WIDE_OPEN])
      else $error("valve open without wide open flag");
   AST_IDLING: assert property (
      engineState[ST_IDLING] == (engineState[ST_TPS_CLOSED] && !engineState[ST_OVERRUN]))
      else $error("idling flag mismatch");
   AST_HOLD: assert property (
      !sampleValid |=> $stable(engineState) && $stable(overrunCutEn))
      else $error("state moved without update");
   AST_RD_ANS: assert property (
      arvalid && arready |=> rvalid)
      else $error("read answer late");

   // Main scenarios reached
   cover property (overrunCutEn);
   cover property (closedLoopIdleEn);
   cover property (idleValveOpenFullThrottle);
endmodule
bind esq_core esq_core_asserts esq_core_asserts_i (.clk, .rst, .sampleValid, .engineState,
   .closedLoopIdleEn, .idleTimingEn, .idleFuelTableEn, .overrunCutEn,
   .idleValveOpenFullThrottle, .arvalid, .arready, .rvalid);
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench of the engine state qualifier
`timescale 1ns/1ns
`default_nettype none
module tb;
   import esq_pkg::*;
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire logic   sampleValid, awready, wready, bvalid, arready, rvalid, irq;
   wire logic   closedLoopIdleEn, idleTimingEn, idleFuelTableEn, overrunCutEn;
   wire logic   idleValveOpenFullThrottle;
   wire logic [15:0] vehicleSpeed, throttlePosition, manifoldPressure, engineSpeedRate;
   wire logic [8:0]  engineState;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   int          failures = 0, cmp_count = 0, cycles = 0;
   int          th[8] = '{80, 100, 400, 100, 400, 10, 994, 256};
   logic [1:0]  ctrl = 2'h0;
   logic [8:0]  lastSt = '0;
   logic [31:0] seed = 32'd35071;

   // Clock generator
   initial forever #25 clk = ~clk;

   esq_sensor_model esq_sensor_model_i (.clk, .sampleValid, .vehicleSpeed, .throttlePosition,
      .manifoldPressure, .engineSpeedRate);
   esq_core esq_core_i (.clk, .rst, .sampleValid, .vehicleSpeed, .throttlePosition,
      .manifoldPressure, .engineSpeedRate, .closedLoopIdleEn, .idleTimingEn, .idleFuelTableEn,
      .overrunCutEn, .idleValveOpenFullThrottle, .engineState, .irq, .awaddr, .awvalid,
      .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Reference outputs: {valve, cut, fuel, timing, loop, state}
   function automatic logic [13:0] model(int s, int t, int m, int r);
      logic [8:0] q;
      logic       ok;
      q = {1'b0, m < th[7], t > th[6], t < th[5], r < -th[4], r < -th[3], r > th[2],
           r > th[1], s > th[0]};
      q[8] = q[5] && !q[7];
      ok = q[5] && !(ctrl[0] && q[0]);
      return {ctrl[1] && q[6], q[5] && q[7] && !q[4] && !q[2], ok, ok,
              ok && q[4:1] == 4'h0 && !q[7], q};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(negedge clk);
         if (awready) aw = 1'b0;
         if (wready) w = 1'b0;
         @(posedge clk);
         awvalid <= aw;
         wvalid <= w;
      end
      bready <= 1'b1;
      do @(negedge clk); while (!bvalid);
      chk(32'(bresp), 32'(RESP_OKAY));
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge clk); while (!arready);
      @(posedge clk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge clk); while (!rvalid);
      d = rdata;
      rs = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   // One sensor update compared against the reference
   task automatic smp(input int s, input int t, input int m, input int r);
      logic [13:0] e;
      e = model(s, t, m, r);
      esq_sensor_model_i.send(s[15:0], t[15:0], m[15:0], r[15:0], 1 + int'(rnd() % 3));
      @(negedge clk);
      chk(32'({idleValveOpenFullThrottle, overrunCutEn, idleFuelTableEn, idleTimingEn,
               closedLoopIdleEn, engineState}), 32'(e));
      lastSt = e[8:0];
   endtask

   // Cycle budget guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      logic [31:0] d, x, y;
      logic [1:0]  rs;
      logic [8:0]  stA, stB;
      int          t;
      int          rv[8] = '{0, 100, 400, 100, 400, 10, 994, 0};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         axr(OFF_THR_BASE + 8'(4 * i), d, rs);
         chk(d, 32'(rv[i]));
      end
      axr(OFF_CTRL, d, rs);
      chk(d, 32'h0);
      axr(8'h40, d, rs);
      chk({d[29:0], rs}, 32'(RESP_SLVERR));
      for (int i = 0; i < 8; i++) begin
         axw(OFF_THR_BASE + 8'(4 * i), 32'(th[i]));
         axr(OFF_THR_BASE + 8'(4 * i), d, rs);
         chk(d, 32'(th[i]));
      end
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         ctrl = 2'(c);
         axw(OFF_CTRL, 32'(c));
         smp(80, 9, 255, 400);
         smp(81, 10, 256, -401);
         smp(0, 0, 0, -100);
         repeat (40) begin
            x = rnd();
            y = rnd();
            case (x[9:8])
               2'd0: t = int'(x[31:28]);
               2'd1: t = 990 + int'(x[31:28]);
               default: t = int'(x[27:18]);
            endcase
            smp(int'(x[7:0]), t, int'(x[24:16]), int'(y[10:0]) - 1024);
         end
      end
      $display("test gating done");
      smp(0, 0, 0, 0);
      stA = lastSt;
      axw(OFF_IRQ_MASK, 32'h1FF);
      axw(OFF_IRQ_STAT, 32'h1FF);
      chk(32'(irq), 32'h0);
      smp(200, 995, 300, -1000);
      chk(32'(irq), 32'h1);
      axr(OFF_IRQ_STAT, d, rs);
      chk(d, 32'(stA ^ lastSt));
      stB = lastSt;
      axw(OFF_IRQ_STAT, 32'h1FF);
      chk(32'(irq), 32'h0);
      axw(OFF_IRQ_MASK, 32'h0);
      smp(0, 0, 0, 0);
      chk(32'(irq), 32'h0);
      axr(OFF_IRQ_STAT, d, rs);
      chk(d, 32'(stB ^ lastSt));
      $display("test interrupt done");
      wrap_up();
   end
endmodule
`default_nettype wire
